// ==== design/rds_peak.sv ====
// Tracks the peak power, and the output frequency at the first threshold hit, seen during one direction test.
// Assumes power and frequency are sampled values synchronous to clk_i.
module rds_peak
  import rds_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic enable_i,
  input wire logic [W-1:0] power_i,
  input wire logic [W-1:0] freq_i,
  input wire logic [W-1:0] thresh_i,
  output logic [W-1:0] power_o,
  output logic [W-1:0] freq_at_hit_o,
  output logic hit_o
);
  logic [W-1:0] power_reg;
  logic [W-1:0] freq_reg;
  logic hit_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      power_reg <= '0;
      freq_reg <= '0;
      hit_reg <= 1'b0;
    end else if (enable_i) begin
      if (power_i > power_reg) begin
        power_reg <= power_i;
      end
      // The frequency is frozen at the first threshold crossing.
      if (!hit_reg && power_i >= thresh_i) begin
        hit_reg <= 1'b1;
        freq_reg <= freq_i;
      end
    end
  end

  assign power_o = power_reg;
  assign freq_at_hit_o = freq_reg;
  assign hit_o = hit_reg;
endmodule

// ==== design/rds_pkg.sv ====
// Package for the rescue direction selector: register map, field positions, timing.
// Assumes a 25 MHz control clock and a 32-bit classic Wishbone register bus.
package rds_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  // Register byte offsets.
  localparam logic [7:0] REG_THRESH = 8'h00;
  localparam logic [7:0] REG_SETUP = 8'h04;
  localparam logic [7:0] REG_DELAY = 8'h08;
  localparam logic [7:0] REG_MINDC = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  // Fields of the direction setup byte.
  localparam int unsigned SETUP_ACT = 0;
  localparam int unsigned SETUP_CRIT = 1;
  localparam int unsigned SETUP_TEST = 2;
  // Reset values.
  localparam logic [7:0] THRESH_RST = 8'h64;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [6:0] DELAY_RST = 7'h00;
  localparam logic [15:0] MINDC_RST = 16'h0000;
  // Setting limits: threshold in percent, delay in hundredths of a second.
  localparam logic [7:0] THRESH_MIN = 8'h01;
  localparam logic [7:0] THRESH_MAX = 8'hc8;
  localparam logic [6:0] DELAY_MAX = 7'h64;
  // One delay step is 10 ms.
  localparam int unsigned DELAY_STEP_MS = 10;
  localparam int unsigned DELAY_STEP_CYC = CLK_HZ / 1000 * DELAY_STEP_MS;
  // Length of each direction test run and of the pause between them, in ms.
  localparam int unsigned TEST_MS = 500;
  localparam int unsigned TEST_CYC = CLK_HZ / 1000 * TEST_MS;
  localparam int unsigned PAUSE_MS = 100;
  localparam int unsigned PAUSE_CYC = CLK_HZ / 1000 * PAUSE_MS;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DELAY = 3'b001,
    ST_TEST_FWD = 3'b010,
    ST_PAUSE = 3'b011,
    ST_TEST_REV = 3'b100,
    ST_RUN = 3'b101,
    ST_CANCEL = 3'b110,
    ST_TRIP = 3'b111
  } rds_state_t;
endpackage

// ==== design/rds_timer.sv ====
// Down-counting timer: loads a count, pulses done when it reaches zero.
// Assumes load is a one-cycle strobe from the sequencer.
module rds_timer
  import rds_pkg::*;
#(
  parameter int unsigned W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] count_i,
  output logic busy_o,
  output logic done_o
);
  logic [W-1:0] cnt_reg;
  logic busy_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else if (load_i) begin
      // Loading one less makes busy last exactly count_i cycles; count_i must not be zero.
      cnt_reg <= count_i - 1'b1;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  assign busy_o = busy_reg;
  assign done_o = busy_reg && (cnt_reg == '0);
endmodule

// ==== design/rds_top.sv ====
// Rescue direction selector: chooses the travel direction during battery rescue.
// Assumes synchronous inputs, measured power in percent and a classic Wishbone master.
// Notes on behaviour
// - Settable power threshold 1..200 percent decides rescue travel direction.
// - Activation bit clear: battery mode follows forward and reverse run terminals.
// - Activation bit set in battery mode: direction from setup bits, not terminals.
// - Criteria bit clear and threshold hit both ways: cancel rescue, no run.
// - Criteria bit set: choose direction with highest frequency at threshold hit.
// - Test bit clear: always run forward; end when run command is withdrawn.
// - Test bit set: test forward, pause, test reverse, finish at lower power.
// - Direction calculation begins after settable delay of 0.00 to 1.00 s.
// - Rescue run allowed only while DC link is strictly above minimum level.
// - DC link at or below minimum trips undervoltage on any run command, except while rescue is cancelled.
//
// Implementation choices: register access over Wishbone and the register addresses.
module rds_top
  import rds_pkg::*;
#(
  parameter int unsigned PW = 16,
  parameter int unsigned TEST_CYCLES = TEST_CYC,
  parameter int unsigned PAUSE_CYCLES = PAUSE_CYC,
  parameter int unsigned STEP_CYCLES = DELAY_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic run_forward_i,
  input wire logic run_reverse_i,
  input wire logic battery_mode_input_i,
  input wire logic [PW-1:0] input_power_i,
  input wire logic [PW-1:0] output_freq_i,
  input wire logic [15:0] dc_link_i,
  output logic motor_fwd_o,
  output logic motor_rev_o,
  output logic undervoltage_trip_o,
  output logic rescue_cancel_o
);
  localparam int unsigned TW = 32;

  logic [7:0] power_threshold_setting_reg;
  logic [7:0] direction_setup_byte_reg;
  logic [6:0] calc_delay_setting_reg;
  logic [15:0] min_dc_link_level_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic trip_clear_reg;
  rds_state_t state_reg;
  rds_state_t state_next;
  logic [6:0] step_left_reg;
  logic fwd_reg;
  logic rev_reg;
  logic trip_reg;
  logic cancel_reg;

  logic wr_en;
  logic run_cmd;
  logic dc_ok;
  logic calc_on;
  logic tmr_load;
  logic [TW-1:0] tmr_count;
  logic tmr_busy;
  logic tmr_done;
  logic fwd_clear;
  logic rev_clear;
  logic [PW-1:0] fwd_power;
  logic [PW-1:0] rev_power;
  logic [PW-1:0] fwd_freq;
  logic [PW-1:0] rev_freq;
  logic fwd_hit;
  logic rev_hit;
  logic [PW-1:0] thresh_ext;

  // Writes land at the edge that completes the handshake, while ack is high.
  assign wr_en = cyc_i && stb_i && we_i && ack_reg;
  assign run_cmd = run_forward_i || run_reverse_i;
  assign dc_ok = dc_link_i > min_dc_link_level_reg;
  assign calc_on = direction_setup_byte_reg[SETUP_ACT] && battery_mode_input_i;
  assign thresh_ext = PW'(power_threshold_setting_reg);

  // Bus answer: ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cyc_i && stb_i && !ack_reg;
    end
  end

  // Threshold writes are clamped into the 1..200 percent range.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_threshold_setting_reg <= THRESH_RST;
    end else if (wr_en && adr_i == REG_THRESH && sel_i[0]) begin
      if (dat_i[7:0] < THRESH_MIN) begin
        power_threshold_setting_reg <= THRESH_MIN;
      end else if (dat_i[7:0] > THRESH_MAX) begin
        power_threshold_setting_reg <= THRESH_MAX;
      end else begin
        power_threshold_setting_reg <= dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      direction_setup_byte_reg <= SETUP_RST;
    end else if (wr_en && adr_i == REG_SETUP && sel_i[0]) begin
      direction_setup_byte_reg <= dat_i[7:0];
    end
  end

  // Delay is in 10 ms steps, capped at one second.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      calc_delay_setting_reg <= DELAY_RST;
    end else if (wr_en && adr_i == REG_DELAY && sel_i[0]) begin
      if (dat_i[6:0] > DELAY_MAX || dat_i[7]) begin
        calc_delay_setting_reg <= DELAY_MAX;
      end else begin
        calc_delay_setting_reg <= dat_i[6:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      min_dc_link_level_reg <= MINDC_RST;
    end else if (wr_en && adr_i == REG_MINDC) begin
      if (sel_i[0]) begin
        min_dc_link_level_reg[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        min_dc_link_level_reg[15:8] <= dat_i[15:8];
      end
    end
  end

  // Writing bit 0 of the control register clears a latched cancel, or a trip unless a run command still meets a low link voltage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_clear_reg <= 1'b0;
    end else begin
      trip_clear_reg <= wr_en && adr_i == REG_CTRL && sel_i[0] && dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_reg) begin
      unique case (adr_i)
        REG_THRESH: dat_reg <= {24'h00_0000, power_threshold_setting_reg};
        REG_SETUP: dat_reg <= {24'h00_0000, direction_setup_byte_reg};
        REG_DELAY: dat_reg <= {25'h000_0000, calc_delay_setting_reg};
        REG_MINDC: dat_reg <= {16'h0000, min_dc_link_level_reg};
        REG_STATUS: dat_reg <= {22'h00_0000, dc_ok, fwd_hit, rev_hit, state_reg,
                                cancel_reg, trip_reg, rev_reg, fwd_reg};
        default: dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // Sequencer.
  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_count = '0;
    fwd_clear = 1'b0;
    rev_clear = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (run_cmd && !dc_ok) begin
          state_next = ST_TRIP;
        end else if (run_cmd && calc_on) begin
          state_next = ST_DELAY;
          // A zero delay loads no step, so the calculation starts at once.
          tmr_load = (calc_delay_setting_reg != '0);
          tmr_count = STEP_CYCLES;
          fwd_clear = 1'b1;
          rev_clear = 1'b1;
        end
      end
      ST_DELAY: begin
        if (!run_cmd) begin
          state_next = ST_IDLE;
        end else if (step_left_reg == '0 && !tmr_busy) begin
          state_next = direction_setup_byte_reg[SETUP_TEST] ? ST_TEST_FWD : ST_RUN;
          tmr_load = direction_setup_byte_reg[SETUP_TEST];
          tmr_count = TEST_CYCLES;
        end else if (tmr_done && step_left_reg > 7'h01) begin
          tmr_load = 1'b1;
          tmr_count = STEP_CYCLES;
        end
      end
      ST_TEST_FWD: begin
        if (!run_cmd) begin
          state_next = ST_IDLE;
        end else if (tmr_done) begin
          state_next = ST_PAUSE;
          tmr_load = 1'b1;
          tmr_count = PAUSE_CYCLES;
        end
      end
      ST_PAUSE: begin
        if (!run_cmd) begin
          state_next = ST_IDLE;
        end else if (tmr_done) begin
          state_next = ST_TEST_REV;
          tmr_load = 1'b1;
          tmr_count = TEST_CYCLES;
        end
      end
      ST_TEST_REV: begin
        if (!run_cmd) begin
          state_next = ST_IDLE;
        end else if (tmr_done) begin
          if (fwd_hit && rev_hit && !direction_setup_byte_reg[SETUP_CRIT]) begin
            state_next = ST_CANCEL;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (!run_cmd) begin
          state_next = ST_IDLE;
        end
      end
      ST_CANCEL: begin
        if (trip_clear_reg) begin
          state_next = ST_IDLE;
        end
      end
      ST_TRIP: begin
        if (trip_clear_reg && !(run_cmd && !dc_ok)) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // A run only continues while the link voltage holds.
    if (state_reg != ST_IDLE && state_reg != ST_TRIP && state_reg != ST_CANCEL
        && run_cmd && !dc_ok) begin
      state_next = ST_TRIP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Delay is counted in whole steps so the timer stays narrow in meaning.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_left_reg <= DELAY_RST;
    end else if (state_reg == ST_IDLE) begin
      step_left_reg <= calc_delay_setting_reg;
    end else if (state_reg == ST_DELAY && tmr_done && step_left_reg != '0) begin
      step_left_reg <= step_left_reg - 7'h01;
    end
  end

  // Direction choice once the tests are done.
  logic pick_rev;
  always_comb begin
    pick_rev = 1'b0;
    if (direction_setup_byte_reg[SETUP_TEST]) begin
      if (fwd_hit && rev_hit) begin
        pick_rev = rev_freq > fwd_freq;
      end else if (fwd_hit != rev_hit) begin
        pick_rev = fwd_hit;
      end else begin
        pick_rev = rev_power < fwd_power;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_reg <= 1'b0;
      rev_reg <= 1'b0;
    end else if (!battery_mode_input_i || !direction_setup_byte_reg[SETUP_ACT]) begin
      fwd_reg <= run_forward_i && !run_reverse_i && dc_ok && state_next != ST_TRIP;
      rev_reg <= run_reverse_i && !run_forward_i && dc_ok && state_next != ST_TRIP;
    end else begin
      unique case (state_next)
        ST_TEST_FWD: begin
          fwd_reg <= 1'b1;
          rev_reg <= 1'b0;
        end
        ST_TEST_REV: begin
          fwd_reg <= 1'b0;
          rev_reg <= 1'b1;
        end
        ST_RUN: begin
          fwd_reg <= !pick_rev;
          rev_reg <= pick_rev;
        end
        default: begin
          fwd_reg <= 1'b0;
          rev_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_reg <= 1'b0;
      cancel_reg <= 1'b0;
    end else begin
      trip_reg <= state_next == ST_TRIP;
      cancel_reg <= state_next == ST_CANCEL;
    end
  end

  assign motor_fwd_o = fwd_reg;
  assign motor_rev_o = rev_reg;
  assign undervoltage_trip_o = trip_reg;
  assign rescue_cancel_o = cancel_reg;

  rds_timer #(.W(TW)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  rds_peak #(.W(PW)) u_peak_fwd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(fwd_clear),
    .enable_i(state_reg == ST_TEST_FWD),
    .power_i(input_power_i),
    .freq_i(output_freq_i),
    .thresh_i(thresh_ext),
    .power_o(fwd_power),
    .freq_at_hit_o(fwd_freq),
    .hit_o(fwd_hit)
  );

  rds_peak #(.W(PW)) u_peak_rev (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(rev_clear),
    .enable_i(state_reg == ST_TEST_REV),
    .power_i(input_power_i),
    .freq_i(output_freq_i),
    .thresh_i(thresh_ext),
    .power_o(rev_power),
    .freq_at_hit_o(rev_freq),
    .hit_o(rev_hit)
  );
endmodule

// ==== tb/rds_checker.sv ====
// Checker for the rescue direction selector, bound to rds_top.
// Assumes one clock domain; keeps shadows of the setup byte and minimum level.
module rds_checker
  import rds_pkg::*;
#(
  parameter int unsigned PW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic run_forward_i,
  input wire logic run_reverse_i,
  input wire logic battery_mode_input_i,
  input wire logic [PW-1:0] input_power_i,
  input wire logic [PW-1:0] output_freq_i,
  input wire logic [15:0] dc_link_i,
  input wire logic motor_fwd_o,
  input wire logic motor_rev_o,
  input wire logic undervoltage_trip_o,
  input wire logic rescue_cancel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] min_reg;
  logic [7:0] setup_reg;
  logic take, wr, low, halt, calc, follow;
  assign take = cyc_i && stb_i && !ack_o;
  assign wr = cyc_i && stb_i && we_i;
  assign low = dc_link_i <= min_reg;
  assign halt = undervoltage_trip_o || rescue_cancel_o;
  assign calc = battery_mode_input_i && setup_reg[SETUP_ACT] && !setup_reg[SETUP_TEST];
  assign follow = (!battery_mode_input_i || !setup_reg[SETUP_ACT]) && run_forward_i
    && !run_reverse_i && !low && !halt;
  // Shadows follow the bus so that trip checks need no read-back of their own.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      min_reg <= MINDC_RST;
      setup_reg <= SETUP_RST;
    end else if (wr && ack_o) begin
      if (adr_i == REG_MINDC && sel_i[0]) min_reg[7:0] <= dat_i[7:0];
      if (adr_i == REG_MINDC && sel_i[1]) min_reg[15:8] <= dat_i[15:8];
      if (adr_i == REG_SETUP && sel_i[0]) setup_reg <= dat_i[7:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held over one cycle");
  ack_answer_a: assert property (take |=> ack_o)
    else $error("request not answered");
  rd_unmapped_a: assert property (take && !we_i && adr_i == 8'h20 |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  follow_run_a: assert property (follow |=> motor_fwd_o)
    else $error("forward terminal not followed");
  calc_fwd_a: assert property (calc && $past(calc) && !$past(motor_rev_o) |-> !motor_rev_o)
    else $error("reverse driven with test bit clear");
  dc_low_a: assert property ((run_forward_i || run_reverse_i) && low && !rescue_cancel_o
    |=> undervoltage_trip_o)
    else $error("no trip on low link voltage");
  run_dc_a: assert property (motor_fwd_o || motor_rev_o |-> $past(dc_link_i) > $past(min_reg))
    else $error("run with link voltage too low");
  halt_quiet_a: assert property (halt |-> !motor_fwd_o && !motor_rev_o)
    else $error("motor driven while halted");
  trip_hold_a: assert property (undervoltage_trip_o && !wr && !$past(wr) && !$past(wr, 2)
    && !$past(wr, 3) && !$past(wr, 4) |=> undervoltage_trip_o)
    else $error("trip dropped without clear");
  no_both_a: assert property (!(motor_fwd_o && motor_rev_o))
    else $error("both directions driven");
  cover property ($rose(motor_fwd_o));
  cover property ($rose(motor_rev_o));
  cover property ($rose(undervoltage_trip_o));
  cover property ($rose(rescue_cancel_o));
endmodule

// ==== tb/rds_lift_ctrl.sv ====
// Lift controller model: turns bench requests into run and battery lines.
// Assumes requests change just after a rising edge of clk_i.
module rds_lift_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_fwd_i,
  input wire logic req_rev_i,
  input wire logic battery_i,
  input wire logic ready_i,
  input wire logic slow_i,
  output logic run_forward_o,
  output logic run_reverse_o,
  output logic battery_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_reg;
  logic go;
  always_ff @(posedge clk_i) begin
    battery_mode_o <= battery_i && !rst_i;
    if (rst_i || !(req_fwd_i || req_rev_i)) begin
      wait_reg <= 2'h0;
    end else if (wait_reg != 2'h3) begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
  // A run goes out only once ready_i reports ready; slow mode polls late.
  assign go = ready_i && (!slow_i || wait_reg == 2'h3);
  assign run_forward_o = req_fwd_i && go;
  assign run_reverse_o = req_rev_i && go;
endmodule

// ==== tb/tb_rds_top.sv ====
// Testbench for the rescue direction selector with a lift controller model.
// Assumes shortened sequence counts and a 25 MHz clock.
module tb_rds_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rds_pkg::*;
  localparam int unsigned TC = 20;
  localparam int unsigned PC = 10;
  localparam int unsigned SC = 5;
  localparam logic [7:0] SU [3] = '{8'h05, 8'h05, 8'h07};
  localparam logic [7:0] TH [3] = '{8'hc8, 8'h32, 8'h32};
  localparam logic [15:0] PR [3] = '{16'h0028, 16'h005a, 16'h005a};
  localparam logic [15:0] FF [3] = '{16'h0000, 16'h0000, 16'h02bc};
  localparam logic [3:0] EX [3] = '{4'h2, 4'h8, 4'h1};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, obs;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  logic ack_o, run_forward, run_reverse, trip, canc, run_f, run_r, batt;
  logic req_f = 1'b0, req_r = 1'b0, bat_req = 1'b0, ready = 1'b0, slow = 1'b0;
  logic [15:0] pw = 16'h0000, fq = 16'h0000, dc = 16'h0000;
  logic [15:0] pw_f = 16'h0050, pw_r = 16'h0000, fq_f = 16'h0000, fq_r = 16'h012c;
  int bad_count = 0;
  int checks = 0;
  assign obs = {canc, trip, run_reverse, run_forward};
  always #20 clk_i = ~clk_i;
  // Motor plant: power and frequency follow the direction being driven.
  always @(posedge clk_i) begin
    pw <= run_forward ? pw_f : run_reverse ? pw_r : 16'h0000;
    fq <= run_forward ? fq_f : run_reverse ? fq_r : 16'h0000;
  end
  rds_top #(.TEST_CYCLES(TC), .PAUSE_CYCLES(PC), .STEP_CYCLES(SC)) i_dut (
    .clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o, .ack_o, .run_forward_i(run_f), .run_reverse_i(run_r),
    .battery_mode_input_i(batt), .input_power_i(pw), .output_freq_i(fq), .dc_link_i(dc),
    .motor_fwd_o(run_forward), .motor_rev_o(run_reverse), .undervoltage_trip_o(trip), .rescue_cancel_o(canc));
  rds_lift_ctrl i_ctrl (.clk_i, .rst_i, .req_fwd_i(req_f), .req_rev_i(req_r),
    .battery_i(bat_req), .ready_i(ready), .slow_i(slow), .run_forward_o(run_f),
    .run_reverse_o(run_r), .battery_mode_o(batt));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // The request stands until ack is seen high; a missing answer ends the run.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      bad_count++;
      results();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rdat, exp);
  endtask
  task automatic wait_hi(input int k, input int bound, output int n);
    n = 0;
    while (obs[k] !== 1'b1 && n < bound) begin
      @(negedge clk_i);
      n++;
    end
    if (obs[k] !== 1'b1) begin
      bad_count++;
      results();
    end
  endtask
  task automatic settle();
    @(posedge clk_i);
    req_f <= 1'b0;
    req_r <= 1'b0;
    dc <= 16'h0101;
    repeat (3) @(posedge clk_i);
    bus(1'b1, REG_CTRL, 32'h0000_0001);
    repeat (4) @(negedge clk_i);
    check(32'(obs), 32'h0000_0000);
  endtask
  initial begin
    int n;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_THRESH, {24'h00_0000, THRESH_RST});
    rd(REG_SETUP, {24'h00_0000, SETUP_RST});
    rd(REG_DELAY, {25'h000_0000, DELAY_RST});
    rd(REG_MINDC, {16'h0000, MINDC_RST});
    bus(1'b1, 8'h20, 32'h0000_00ff);
    rd(8'h20, 32'h0000_0000);
    bus(1'b1, REG_THRESH, 32'h0000_0000);
    rd(REG_THRESH, {24'h00_0000, THRESH_MIN});
    bus(1'b1, REG_THRESH, 32'h0000_00ff);
    rd(REG_THRESH, {24'h00_0000, THRESH_MAX});
    bus(1'b1, REG_DELAY, 32'h0000_007f);
    rd(REG_DELAY, {25'h000_0000, DELAY_MAX});
    $display("Test registers done");
    dc <= 16'h0101;
    bat_req <= 1'b1;
    ready <= 1'b1;
    bus(1'b1, REG_MINDC, 32'h0000_0100);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      req_f <= (k == 0);
      req_r <= (k == 1);
      slow <= (k == 1);
      wait_hi(k, 8, n);
      check(32'({run_reverse, run_forward}), k == 0 ? 32'h0000_0001 : 32'h0000_0002);
      settle();
    end
    slow <= 1'b0;
    $display("Test terminal follow done");
    bus(1'b1, REG_SETUP, 32'h0000_0001);
    bus(1'b1, REG_DELAY, 32'h0000_0002);
    @(posedge clk_i);
    req_r <= 1'b1;
    wait_hi(0, 60, n);
    check(32'(n >= 2 * SC), 32'h0000_0001);
    check(32'(run_reverse), 32'h0000_0000);
    settle();
    $display("Test forward only done");
    bus(1'b1, REG_DELAY, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, REG_SETUP, {24'h00_0000, SU[k]});
      bus(1'b1, REG_THRESH, {24'h00_0000, TH[k]});
      pw_r <= PR[k];
      fq_f <= FF[k];
      @(posedge clk_i);
      req_r <= 1'b1;
      wait_hi(0, 40, n);
      n = 0;
      while (run_forward === 1'b1 && n < 100) begin
        @(negedge clk_i);
        n++;
      end
      check(n, TC);
      repeat (PC + TC + 15) @(negedge clk_i);
      check(32'(obs), 32'(EX[k]));
      settle();
    end
    $display("Test direction search done");
    @(posedge clk_i);
    dc <= 16'h0100;
    req_f <= 1'b1;
    wait_hi(2, 8, n);
    check(32'({run_reverse, run_forward}), 32'h0000_0000);
    rd(REG_STATUS, 32'h0000_01f4);
    settle();
    $display("Test undervoltage done");
    results();
  end
endmodule
bind rds_top rds_checker #(.PW(PW)) i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .run_forward_i, .run_reverse_i, .battery_mode_input_i,
  .input_power_i, .output_freq_i, .dc_link_i, .motor_fwd_o, .motor_rev_o,
  .undervoltage_trip_o, .rescue_cancel_o);
